// [src/mprf_part_filter.sv]
// Per-part MIDI receive filter with sustain mapping and effect copy control.
// Assumes decoded MIDI messages arrive as one-cycle strobes on clk; panel
// settings are synchronous levels from the same domain.
`timescale 1ns/1ps
module mprf_part_filter #(
	parameter int COPY_SHOW_CYC = mprf_pkg::COPY_SHOW_CYC
) (
	input  wire logic       clk,            // 200 MHz clock.
	input  wire logic       rst,            // Synchronous reset, active high.
	input  wire logic       msg_valid,      // One-cycle strobe of a decoded message.
	input  wire logic [3:0] msg_kind,       // Status high nibble.
	input  wire logic [3:0] msg_chan,       // Channel 0..15.
	input  wire logic [6:0] msg_d1,         // First data byte.
	input  wire logic [6:0] msg_d2,         // Second data byte.
	input  wire logic [4:0] chan_set,       // Channel setting 0..15, Omni, Global.
	input  wire logic       chan_set_wr,    // Strobe: load chan_set.
	input  wire logic [3:0] global_chan,    // Global MIDI channel.
	input  wire logic       page_down_held, // Page-down button held.
	input  wire logic       multi_mode,     // Multi-part mode active.
	input  wire logic       voice_off,      // Voice allocation set to Off.
	input  wire logic       pc_block,       // Part program-change block On.
	input  wire logic       cc_block,       // Part controller block On.
	input  wire logic       glb_pc_en,      // Global program change enabled.
	input  wire logic       glb_cc_en,      // Global control change enabled.
	input  wire logic [3:0] sus_map,        // Sustain mapping code.
	input  wire logic [1:0] out_pair_set,   // Output pair selection 0..3.
	input  wire logic       fx_from_prog,   // Effects source is Program.
	input  wire logic       write_p2b,      // Write pressed on copy-to-part page.
	input  wire logic       write_b2p,      // Write pressed on copy-to-program page.
	input  wire logic [3:0] copy_sel,       // 0 all, 1..8 one effect group.
	input  wire logic       midi_btn,       // MIDI settings button strobe.
	input  wire logic       sysex_page,     // Sysex transmit page shown.
	output logic [4:0]      chan_r,         // Stored channel setting.
	output logic [3:0]      rx_chan_r,      // Resolved receive/transmit channel.
	output logic            omni_r,         // Part listens on all channels.
	output logic [1:0]      out_pair_r,     // Routed output pair.
	output logic            env_hold_r,     // Envelopes held at sustain.
	output logic            arp_latch_r,    // Arpeggio hold on.
	output logic            arp_mute_r,     // Arpeggio mute on.
	output logic            part_mute_r,    // Part mute on.
	output logic            prog_chg_r,     // Pulse: program change accepted.
	output logic [6:0]      prog_num_r,     // Accepted program number.
	output logic            fx_load_r,      // Pulse: load program effects to part.
	output logic            ctrl_r,         // Pulse: controller accepted.
	output logic [6:0]      ctrl_num_r,     // Accepted controller number.
	output logic [6:0]      ctrl_val_r,     // Accepted controller value.
	output logic            copy_go_r,      // Pulse: start effect copy.
	output logic            copy_dir_r,     // 0 program to buffer, 1 buffer to program.
	output logic [7:0]      copy_mask_r,    // Effect groups to copy.
	output logic            copy_show_r,    // Copy indication shown.
	output logic            midi_menu_r,    // Pulse: open MIDI menu.
	output logic            sysex_dump_r    // Pulse: start sysex dump.
);

	// ---------------------------------------------------------------
	// Elaboration checks
	// ---------------------------------------------------------------
	if (COPY_SHOW_CYC < 1)
	begin : g_bad_show
		$error("COPY_SHOW_CYC must be at least one");
	end

	localparam int SHW = $clog2(COPY_SHOW_CYC + 1);

	// ---------------------------------------------------------------
	// Channel resolution and acceptance decode
	// ---------------------------------------------------------------
	logic [3:0] chan_res;
	logic       chan_omni;
	logic       on_chan;
	logic       active;
	logic       is_note;
	logic       is_pc;
	logic       is_cc;
	logic       is_bank;
	logic       pc_ok;
	logic       cc_ok;
	logic       learn;
	logic       sus_msg;
	logic       pedal_on;
	logic       pedal_eff;
	logic [2:0] sus_fn;
	logic [7:0] sel_mask;

	// Global follows the live global channel, not a snapshot.
	assign chan_res  = (chan_r == mprf_pkg::CH_GLOBAL) ? global_chan : chan_r[3:0];
	assign chan_omni = (chan_r == mprf_pkg::CH_OMNI);
	assign on_chan   = chan_omni || (msg_chan == chan_res);
	// Voice allocation Off only silences the part in multi-part mode.
	assign active    = !(voice_off && multi_mode);
	assign is_note   = (msg_kind == mprf_pkg::ST_NOTE_ON) || (msg_kind == mprf_pkg::ST_NOTE_OFF);
	assign is_pc     = (msg_kind == mprf_pkg::ST_PROG);
	assign is_cc     = (msg_kind == mprf_pkg::ST_CTRL);
	assign is_bank   = (msg_d1 == mprf_pkg::CC_BANK_MSB) || (msg_d1 == mprf_pkg::CC_BANK_LSB);
	assign pc_ok     = msg_valid && active && on_chan && is_pc && glb_pc_en && !pc_block;
	// Bank selects follow the program-change block only, never the controller block.
	assign cc_ok     = msg_valid && active && on_chan && is_cc && glb_cc_en
	                   && (is_bank ? !pc_block : !cc_block);
	// Learning uses the arrival channel, so it can never yield Omni or Global.
	assign learn     = msg_valid && active && is_note && page_down_held;
	assign sus_msg   = cc_ok && (msg_d1 == mprf_pkg::CC_SUSTAIN);
	assign pedal_on  = (msg_d2 >= mprf_pkg::PEDAL_ON_MIN);
	assign pedal_eff = pedal_on ^ sus_map[mprf_pkg::SUS_INV_BIT];
	assign sus_fn    = {1'b0, sus_map[1:0]};

	// Copy mask: all groups, or a single one.
	assign sel_mask  = (copy_sel == mprf_pkg::COPY_ALL) ? {mprf_pkg::FX_GROUPS{1'b1}}
	                   : (8'h01 << (copy_sel[2:0] - 3'h1));

	// ---------------------------------------------------------------
	// Channel setting and routing
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			chan_r     <= mprf_pkg::CH_RESET;
			out_pair_r <= mprf_pkg::OUT_PAIR_RESET;
		end
		else
		begin
			if (learn)
				chan_r <= {1'b0, msg_chan};
			else if (chan_set_wr && chan_set <= mprf_pkg::CH_GLOBAL)
				chan_r <= chan_set;
			out_pair_r <= out_pair_set;
		end
	end

	// Resolved channel is registered so the outputs come from flip-flops.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_chan_r <= 4'h0;
			omni_r    <= 1'b0;
		end
		else
		begin
			rx_chan_r <= chan_res;
			omni_r    <= chan_omni;
		end
	end

	// ---------------------------------------------------------------
	// Sustain pedal mapping
	// ---------------------------------------------------------------
	// A mapping change leaves the functions where they are; the next pedal
	// message drives only the function that the new mapping selects.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			env_hold_r  <= 1'b0;
			arp_latch_r <= 1'b0;
			arp_mute_r  <= 1'b0;
			part_mute_r <= 1'b0;
		end
		else if (sus_msg && sus_map != mprf_pkg::SUS_OFF && !sus_map[3])
		begin
			unique case (sus_fn[1:0])
				mprf_pkg::SUS_ENABLE[1:0]:    env_hold_r  <= pedal_eff;
				mprf_pkg::SUS_ARP_LATCH[1:0]: arp_latch_r <= pedal_eff;
				mprf_pkg::SUS_ARP_MUTE[1:0]:  arp_mute_r  <= pedal_eff;
				mprf_pkg::SUS_PART_MUTE[1:0]: part_mute_r <= pedal_eff;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Accepted program changes and controllers
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prog_chg_r <= 1'b0;
			prog_num_r <= 7'h00;
			fx_load_r  <= 1'b0;
			ctrl_r     <= 1'b0;
			ctrl_num_r <= 7'h00;
			ctrl_val_r <= 7'h00;
		end
		else
		begin
			prog_chg_r <= pc_ok;
			fx_load_r  <= pc_ok && fx_from_prog;
			ctrl_r     <= cc_ok;
			if (pc_ok)
				prog_num_r <= msg_d1;
			if (cc_ok)
			begin
				ctrl_num_r <= msg_d1;
				ctrl_val_r <= msg_d2;
			end
		end
	end

	// ---------------------------------------------------------------
	// Effect copy utilities and indication timer
	// ---------------------------------------------------------------
	mprf_pkg::mprf_copy_e copy_st_r;
	logic [SHW-1:0]       show_cnt_r;
	logic                 copy_req;
	logic                 sel_ok;

	// A copy request while one is still shown restarts the indication.
	assign sel_ok   = copy_sel <= 4'(mprf_pkg::FX_GROUPS);
	assign copy_req = (write_p2b || write_b2p) && sel_ok;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			copy_st_r   <= mprf_pkg::mprf_idle;
			copy_go_r   <= 1'b0;
			copy_dir_r  <= 1'b0;
			copy_mask_r <= 8'h00;
		end
		else
		begin
			copy_go_r <= copy_req;
			if (copy_req)
			begin
				copy_dir_r  <= write_b2p && !write_p2b;
				copy_mask_r <= sel_mask;
				copy_st_r   <= write_p2b ? mprf_pkg::mprf_copy_p2b : mprf_pkg::mprf_copy_b2p;
			end
			else if (show_cnt_r == '0)
				copy_st_r <= mprf_pkg::mprf_idle;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			show_cnt_r  <= '0;
			copy_show_r <= 1'b0;
		end
		else
		begin
			if (copy_req)
				show_cnt_r <= SHW'(COPY_SHOW_CYC - 1);
			else if (show_cnt_r != '0)
				show_cnt_r <= show_cnt_r - 1'b1;
			copy_show_r <= copy_req || (show_cnt_r != '0);
		end
	end

	// ---------------------------------------------------------------
	// MIDI settings control
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			midi_menu_r  <= 1'b0;
			sysex_dump_r <= 1'b0;
		end
		else
		begin
			sysex_dump_r <= midi_btn && sysex_page;
			midi_menu_r  <= midi_btn && !sysex_page && multi_mode;
		end
	end

endmodule // mprf_part_filter

// [src/mprf_pkg.sv]
// Package for the per-part receive filter: encodings and sizes.
// Assumes importer-free users; every reference is written mprf_pkg::name.
package mprf_pkg;

	// ---------------------------------------------------------------
	// Message kinds and controller numbers
	// ---------------------------------------------------------------
	localparam logic [3:0] ST_NOTE_OFF = 4'h8;
	localparam logic [3:0] ST_NOTE_ON  = 4'h9;
	localparam logic [3:0] ST_CTRL     = 4'hb;
	localparam logic [3:0] ST_PROG     = 4'hc;
	localparam logic [6:0] CC_BANK_MSB = 7'h00;
	localparam logic [6:0] CC_BANK_LSB = 7'h20;
	localparam logic [6:0] CC_SUSTAIN  = 7'h40;
	localparam logic [6:0] PEDAL_ON_MIN = 7'h40;

	// ---------------------------------------------------------------
	// Channel setting: 0..15 fixed, then Omni, then Global
	// ---------------------------------------------------------------
	localparam logic [4:0] CH_OMNI   = 5'h10;
	localparam logic [4:0] CH_GLOBAL = 5'h11;
	localparam logic [4:0] CH_RESET  = 5'h11;

	// ---------------------------------------------------------------
	// Sustain mapping codes; bit 2 marks the inverted variants
	// ---------------------------------------------------------------
	localparam logic [3:0] SUS_ENABLE    = 4'h0;
	localparam logic [3:0] SUS_ARP_LATCH = 4'h1;
	localparam logic [3:0] SUS_ARP_MUTE  = 4'h2;
	localparam logic [3:0] SUS_PART_MUTE = 4'h3;
	localparam logic [3:0] SUS_OFF       = 4'h8;
	localparam int         SUS_INV_BIT   = 2;

	// ---------------------------------------------------------------
	// Copy selection: 0 all, 1..8 one group; effect groups
	// ---------------------------------------------------------------
	localparam int         FX_GROUPS   = 8;
	localparam logic [3:0] COPY_ALL    = 4'h0;
	localparam logic [1:0] OUT_PAIR_RESET = 2'h0;
	localparam logic [1:0] OUT_PAIRS_LAST = 2'h3;

	// ---------------------------------------------------------------
	// Timing: copy indication time and its cycle count at 200 MHz
	// ---------------------------------------------------------------
	localparam int CLK_MHZ        = 200;
	localparam int COPY_SHOW_MS   = 500;
	localparam int COPY_SHOW_CYC  = COPY_SHOW_MS * 1000 * CLK_MHZ;

	typedef enum logic [1:0] {mprf_idle, mprf_copy_p2b, mprf_copy_b2p} mprf_copy_e;
endpackage

// [tb/mprf_part_filter_chk.sv]
// Checker for the per-part receive filter: timing relations at its ports.
// Assumes binding into mprf_part_filter and one clock with synchronous reset.
`timescale 1ns/1ps
module mprf_part_filter_chk #(
	parameter int COPY_SHOW_CYC = 8
) (
	input wire logic       clk,          // Clock.
	input wire logic       rst,          // Reset.
	input wire logic       msg_valid,    // Message strobe.
	input wire logic [3:0] msg_kind,     // Status nibble.
	input wire logic [3:0] msg_chan,     // Channel.
	input wire logic [6:0] msg_d1,       // First data byte.
	input wire logic       multi_mode,   // Multi mode.
	input wire logic       voice_off,    // Voice off.
	input wire logic       pc_block,     // Program block.
	input wire logic       cc_block,     // Controller block.
	input wire logic       glb_pc_en,    // Global program enable.
	input wire logic       glb_cc_en,    // Global controller enable.
	input wire logic       fx_from_prog, // Effects source.
	input wire logic       write_p2b,    // Copy to buffer.
	input wire logic       write_b2p,    // Copy to program.
	input wire logic       midi_btn,     // MIDI button.
	input wire logic       sysex_page,   // Sysex page.
	input wire logic [3:0] rx_chan_r,    // Receive channel.
	input wire logic       omni_r,       // Omni.
	input wire logic       prog_chg_r,   // Program pulse.
	input wire logic       fx_load_r,    // Effects load pulse.
	input wire logic       ctrl_r,       // Controller pulse.
	input wire logic       copy_go_r,    // Copy pulse.
	input wire logic       copy_dir_r,   // Copy direction.
	input wire logic       copy_show_r,  // Copy indication.
	input wire logic       midi_menu_r,  // Menu pulse.
	input wire logic       sysex_dump_r  // Dump pulse.
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Bank selects are told apart because the program block drops them in place of the controller block.
	wire is_cc = msg_valid && msg_kind == mprf_pkg::ST_CTRL;
	wire bank  = msg_d1 == mprf_pkg::CC_BANK_MSB || msg_d1 == mprf_pkg::CC_BANK_LSB;
	int  show_n;
	// Counts the cycles that the copy indication stands.
	always_ff @(posedge clk)
		show_n <= (rst || !copy_show_r) ? 0 : show_n + 1;
	a_prog_blocked: assert property (msg_valid && msg_kind == mprf_pkg::ST_PROG && (pc_block || !glb_pc_en)
		|=> !prog_chg_r) else $error("program change passed a closed filter");
	a_bank_blocked: assert property (is_cc && bank && (pc_block || !glb_cc_en) |=> !ctrl_r)
		else $error("bank select passed a closed filter");
	a_cc_blocked: assert property (is_cc && !bank && (cc_block || !glb_cc_en) |=> !ctrl_r)
		else $error("controller passed a closed filter");
	a_fx_follow: assert property (fx_load_r == (prog_chg_r && $past(fx_from_prog)))
		else $error("effects load does not follow the source setting");
	a_off_channel: assert property (msg_valid && !omni_r && msg_chan != rx_chan_r |=> !prog_chg_r && !ctrl_r)
		else $error("off-channel message accepted");
	a_voice_off: assert property (msg_valid && voice_off && multi_mode |=> !prog_chg_r && !ctrl_r)
		else $error("disabled part accepted a message");
	a_copy_show: assert property ($fell(copy_show_r) |-> show_n == COPY_SHOW_CYC)
		else $error("copy indication length wrong");
	a_copy_dir: assert property (copy_go_r |-> $past(write_p2b || write_b2p) && copy_dir_r == !$past(write_p2b))
		else $error("copy direction wrong");
	a_midi_button: assert property (midi_btn |=> sysex_dump_r == $past(sysex_page)
		&& midi_menu_r == ($past(multi_mode) && !$past(sysex_page))) else $error("MIDI button action wrong");
endmodule // mprf_part_filter_chk

bind mprf_part_filter mprf_part_filter_chk #(.COPY_SHOW_CYC(COPY_SHOW_CYC)) chk_i (.clk, .rst, .msg_valid,
	.msg_kind, .msg_chan, .msg_d1, .multi_mode, .voice_off, .pc_block, .cc_block, .glb_pc_en, .glb_cc_en,
	.fx_from_prog, .write_p2b, .write_b2p, .midi_btn, .sysex_page, .rx_chan_r, .omni_r, .prog_chg_r,
	.fx_load_r, .ctrl_r, .copy_go_r, .copy_dir_r, .copy_show_r, .midi_menu_r, .sysex_dump_r);

// [tb/mprf_part_filter_tb.sv]
// Testbench for the per-part receive filter: message and panel sequences.
// Assumes the sequencer model on the message port and the bound checker.
`timescale 1ns/1ps
module mprf_part_filter_tb;
	logic clk = 1'h0, rst = 1'h1, chan_set_wr = 1'h0, page_down_held = 1'h0, multi_mode = 1'h0;
	logic voice_off = 1'h0, pc_block = 1'h0, cc_block = 1'h0, glb_pc_en = 1'h1, glb_cc_en = 1'h1;
	logic fx_from_prog = 1'h1, write_p2b = 1'h0, write_b2p = 1'h0, midi_btn = 1'h0, sysex_page = 1'h0;
	logic [4:0] chan_set = 5'h00, chan_r;
	logic [3:0] global_chan = 4'h3, sus_map = 4'h8, copy_sel = 4'h0, msg_kind, msg_chan, rx_chan_r;
	logic [1:0] out_pair_set = 2'h0, out_pair_r;
	logic [6:0] msg_d1, msg_d2, prog_num_r, ctrl_num_r, ctrl_val_r;
	logic [7:0] copy_mask_r;
	logic msg_valid, omni_r, env_hold_r, arp_latch_r, arp_mute_r, part_mute_r, prog_chg_r, fx_load_r, ctrl_r;
	logic copy_go_r, copy_dir_r, copy_show_r, midi_menu_r, sysex_dump_r;
	int n_errors = 0, checks_done = 0;

	mprf_seq_model seq (.clk, .msg_valid, .msg_kind, .msg_chan, .msg_d1, .msg_d2);
	mprf_part_filter #(.COPY_SHOW_CYC(8)) dut (.clk, .rst, .msg_valid, .msg_kind, .msg_chan, .msg_d1, .msg_d2,
		.chan_set, .chan_set_wr, .global_chan, .page_down_held, .multi_mode, .voice_off, .pc_block, .cc_block,
		.glb_pc_en, .glb_cc_en, .sus_map, .out_pair_set, .fx_from_prog, .write_p2b, .write_b2p, .copy_sel,
		.midi_btn, .sysex_page, .chan_r, .rx_chan_r, .omni_r, .out_pair_r, .env_hold_r, .arp_latch_r,
		.arp_mute_r, .part_mute_r, .prog_chg_r, .prog_num_r, .fx_load_r, .ctrl_r, .ctrl_num_r, .ctrl_val_r,
		.copy_go_r, .copy_dir_r, .copy_mask_r, .copy_show_r, .midi_menu_r, .sysex_dump_r);

	// 200 MHz clock.
	always #2.5 clk = ~clk;

	// Inputs move 1 ns after the edge so no race with the design's sampling.
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [11:0] got, exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic hit(ref logic s);
		tick;
		s = 1'h1;
		tick;
		s = 1'h0;
	endtask
	task automatic print_verdict;
		if (n_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog: the sequence needs under two hundred cycles.
	initial
	begin
		#20000;
		n_errors++;
		print_verdict;
	end

	// Main sequence.
	initial
	begin
		int e;
		logic [6:0] n;
		logic [3:0] s;
		repeat (5) tick;
		rst = 1'h0;
		tick;
		chk(chan_r, mprf_pkg::CH_RESET);
		seq.send(mprf_pkg::ST_PROG, 4'h3, 7'h05, 7'h00);
		chk({prog_chg_r, fx_load_r, prog_num_r}, {2'h3, 7'h05});
		seq.send(mprf_pkg::ST_PROG, 4'h4, 7'h06, 7'h00);
		chk(prog_chg_r, 1'h0);
		global_chan = 4'h4;
		tick;
		tick;
		fx_from_prog = 1'h0;
		seq.send(mprf_pkg::ST_PROG, 4'h4, 7'h07, 7'h00);
		chk({prog_chg_r, fx_load_r}, 2'h2);
		for (int i = 0; i < 4; i++)
		begin
			{glb_pc_en, pc_block} = i[1:0];
			seq.send(mprf_pkg::ST_PROG, 4'h4, 7'h01, 7'h00);
			chk(prog_chg_r, i[1] && !i[0]);
		end
		// Bank selects obey the program block in place of the controller block; other controllers the controller filter.
		for (int i = 0; i < 24; i++)
		begin
			{glb_cc_en, cc_block, pc_block} = i[2:0];
			n = (i[4:3] == 0) ? mprf_pkg::CC_BANK_MSB : (i[4:3] == 1) ? mprf_pkg::CC_BANK_LSB : 7'h07;
			seq.send(mprf_pkg::ST_CTRL, 4'h4, n, 7'h11);
			e = glb_cc_en && ((n == 7'h07) ? !cc_block : !pc_block);
			chk(ctrl_r, e[0]);
			if (e[0])
				chk(ctrl_num_r, n);
		end
		{glb_cc_en, cc_block, pc_block} = 3'h4;
		// Every sustain mapping, straight and inverted, at the pedal threshold, then Off.
		for (int i = 0; i < 9; i++)
		begin
			s = (i == 8) ? mprf_pkg::SUS_OFF : i[3:0];
			sus_map = s;
			seq.send(mprf_pkg::ST_CTRL, 4'h4, mprf_pkg::CC_SUSTAIN, s[2] ? 7'h3f : 7'h40);
			chk({part_mute_r, arp_mute_r, arp_latch_r, env_hold_r}, (i == 8) ? 4'h0 : 4'h1 << s[1:0]);
			seq.send(mprf_pkg::ST_CTRL, 4'h4, mprf_pkg::CC_SUSTAIN, s[2] ? 7'h7f : 7'h00);
			chk({part_mute_r, arp_mute_r, arp_latch_r, env_hold_r}, 4'h0);
		end
		voice_off = 1'h1;
		multi_mode = 1'h1;
		seq.send(mprf_pkg::ST_PROG, 4'h4, 7'h02, 7'h00);
		chk(prog_chg_r, 1'h0);
		multi_mode = 1'h0;
		seq.send(mprf_pkg::ST_PROG, 4'h4, 7'h02, 7'h00);
		chk(prog_chg_r, 1'h1);
		voice_off = 1'h0;
		// Fixed channel, then Omni, then a learned channel.
		chan_set = 5'h09;
		hit(chan_set_wr);
		tick;
		chk({chan_r, rx_chan_r, omni_r}, {5'h09, 4'h9, 1'h0});
		seq.send(mprf_pkg::ST_CTRL, 4'h9, 7'h07, 7'h01);
		chk(ctrl_r, 1'h1);
		seq.send(mprf_pkg::ST_CTRL, 4'h4, 7'h07, 7'h01);
		chk(ctrl_r, 1'h0);
		chan_set = mprf_pkg::CH_OMNI;
		hit(chan_set_wr);
		for (int c = 0; c < 16; c += 15)
		begin
			seq.send(mprf_pkg::ST_CTRL, c[3:0], 7'h07, 7'h01);
			chk({omni_r, ctrl_r}, 2'h3);
		end
		page_down_held = 1'h1;
		seq.send(mprf_pkg::ST_NOTE_ON, 4'hc, 7'h3c, 7'h40);
		page_down_held = 1'h0;
		tick;
		chk({chan_r, omni_r}, {5'h0c, 1'h0});
		for (int p = 0; p < 4; p++)
		begin
			out_pair_set = p[1:0];
			tick;
			tick;
			chk(out_pair_r, p[1:0]);
		end
		// One group to the buffer, then all groups back to the program.
		copy_sel = 4'h3;
		hit(write_p2b);
		chk({copy_go_r, copy_dir_r, copy_show_r, copy_mask_r}, {3'h5, 8'h04});
		repeat (10) tick;
		chk(copy_show_r, 1'h0);
		copy_sel = mprf_pkg::COPY_ALL;
		hit(write_b2p);
		chk({copy_go_r, copy_dir_r, copy_show_r, copy_mask_r}, {3'h7, 8'hff});
		repeat (10) tick;
		for (int i = 0; i < 4; i++)
		begin
			{multi_mode, sysex_page} = i[1:0];
			hit(midi_btn);
			chk({sysex_dump_r, midi_menu_r}, {i[0], i[1] && !i[0]});
		end
		print_verdict;
	end
endmodule // mprf_part_filter_tb

// [tb/mprf_seq_model.sv]
// Sequencer model: sends one decoded channel message at a time.
// Assumes the bench clock; lines change 1 ns after the rising edge.
`timescale 1ns/1ps
module mprf_seq_model (
	input  wire logic       clk,       // Bench clock.
	output logic            msg_valid, // Message strobe.
	output logic [3:0]      msg_kind,  // Status nibble.
	output logic [3:0]      msg_chan,  // Channel.
	output logic [6:0]      msg_d1,    // First data byte.
	output logic [6:0]      msg_d2     // Second data byte.
);
	// Idle lines show the inverse of the last message, so stale data never passes for fresh.
	initial
		{msg_valid, msg_kind, msg_chan, msg_d1, msg_d2} = 23'h0;
	task automatic send(input logic [3:0] k, c, input logic [6:0] a, b);
		@(posedge clk);
		#1;
		{msg_valid, msg_kind, msg_chan, msg_d1, msg_d2} = {1'h1, k, c, a, b};
		@(posedge clk);
		#1;
		{msg_valid, msg_kind, msg_chan, msg_d1, msg_d2} = {1'h0, ~k, ~c, ~a, ~b};
	endtask
endmodule // mprf_seq_model
